// File: logic/rf_synth_regs.svh
// register offsets, field positions, reset values and timing counts of the rf synth control
`ifndef RF_SYNTH_REGS_SVH
`define RF_SYNTH_REGS_SVH

// ****************************************************************
// register offsets
// ****************************************************************
`define REG_RESET_CMD 8'h01
`define REG_GENERAL_CONTROL 8'h31
`define REG_RF_SYNTH_CONTROL 8'h34
`define REG_RF_CP_BLEED 8'h35
`define REG_RF_LOCK_DET 8'h36
`define REG_RF_FAST_ACQ 8'h37
`define REG_RF_REF_DIV 8'h38
`define REG_RF_INT_DIV 8'h39
`define REG_RF_FRAC_LOW 8'h3a
`define REG_RF_FRAC_HIGH 8'h3b
`define REG_OUT_DIV_CONTROL 8'h3f
`define REG_GENERAL_CONTROL_RB 8'hc1
`define REG_DEVICE_STATUS 8'hc4
`define REG_INTERRUPT_ENABLE 8'hc5
`define REG_POWER_STATUS 8'hc6
`define REG_RF_REF_DIV_RB 8'hc8
`define REG_RF_INT_DIV_RB 8'hc9
`define REG_RF_FRAC_LOW_RB 8'hca
`define REG_RF_FRAC_HIGH_RB 8'hcb
`define REG_OUT_DIV_RB 8'hcf

// ****************************************************************
// field positions and codes
// ****************************************************************
`define GC_REF_AMP_BIT 1
`define GC_RF_ENABLE_BIT 2
`define GC_IF_ENABLE_BIT 3
`define CON_MOD_MSB 14
`define CON_MOD_LSB 11
`define CON_RES16_BIT 9
`define MOD_INTEGER 4'h0
`define MOD_MASH111 4'hd
`define LD_FAST_EN_BIT 12
`define LD_DIGITAL_BIT 0
`define LD_COUNT_MSB 11
`define LD_COUNT_LSB 4
`define FA_TIME_MSB 11
`define STAT_LOCK_BIT 0
`define STAT_FAST_BIT 1
`define STAT_REFCLK_BIT 7

// ****************************************************************
// reset values and timing
// ****************************************************************
`define REG_RESET_VALUE 16'h0000
`define CLK_MHZ 25
`define US_TICK_CYCLES (`CLK_MHZ)
`define REF_SETTLE_US 10
`define REF_SETTLE_CYCLES (`REF_SETTLE_US * `CLK_MHZ)

`endif

// File: logic/rf_synth_pkg.sv
// types shared by the rf synth control
`default_nettype none
package rf_synth_pkg;
	// reference clock hold-off states, gray along hold -> settle -> run
	typedef enum logic [1:0] {
		CLK_HOLD = 2'b00,
		CLK_SETTLE = 2'b01,
		CLK_RUN = 2'b11
	} clkgen_state_t;
endpackage
`default_nettype wire

// File: logic/rf_fracn_synth_control.sv
// digital control of the rf fractional-n synthesiser: reset, clock hold-off, divider loading
`timescale 1ns/1ns
`default_nettype none
`include "rf_synth_regs.svh"

// Contract
// (RL1) power-on reset leaves every register and state as a general reset does.
// (RL2) external reset pin low gives the same state as power-on and general reset.
// (RL3) loss of digital or analogue supply asserts internal power-down.
// (RL4) power status register shows one ready bit per regulator.
// (RL5) reference amplifier turns on when the rf or if synthesiser is enabled.
// (RL6) reference clock is gated until stable, then released on a whole cycle.
// (RL7) reference clock stable status is bit 7 of the device status register.
// (RL8) general control bit 2 powers rf synth and amplifier; host sets it first.
// (RL9) charge pump stays high impedance until the main divider is first loaded.
// (RL10) host sets control, lock, fastlock and reference divider before main divider.
// (RL11) once the main divider is loaded the charge pump runs and lock is sought.
// (RL12) integer mode: an integer divider write applies the ratio at once.
// (RL13) 16-bit fractional mode: ratio applies only on the low fraction write.
// (RL14) 24-bit fractional mode: ratio applies only on the low fraction write.
// (RL15) with fastlock enabled, every divider update that takes effect starts fastlock.
// (RL16) fastlock raises charge pump gain and drives fastlock pin, ends after set delay.
// (RL17) lock detector flags lock, selectable analogue or digital method.
// (RL18) modulator takes a 24-bit fraction, step is comparison frequency over 2^24.
// (RL19) host computes rounded integer and signed 24-bit fraction split 8 over 16.
// (RL20) control bits 14..11 = 1101 picks mash 1-1-1; bit 9 clear picks 24-bit.
// (RL21) integer and high fraction are shadowed and moved to the modulator together.
module rf_fracn_synth_control (
	// clock and reset
	input wire logic clk,
	input wire logic rstn,
	input wire logic external_reset_n,
	// supply monitor
	input wire logic digital_supply_ok,
	input wire logic analog_supply_ok,
	input wire logic [3:0] regulator_ready,
	output logic power_down,
	// reference clock
	input wire logic ref_amp_stable,
	output logic ref_amp_enable,
	output logic ref_clk_gate,
	// register port
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_addr,
	input wire logic [15:0] reg_wdata,
	output logic [15:0] reg_rdata,
	output logic reg_rvalid,
	// loop monitors
	input wire logic analog_lock_detect,
	input wire logic phase_in_window,
	// synthesiser controls
	output logic cp_enable,
	output logic cp_gain_boost,
	output logic fast_acquire_output,
	output logic rf_lock,
	output logic [15:0] div_integer,
	output logic [23:0] div_fraction,
	output logic div_update,
	output logic [3:0] modulator_select,
	output logic fraction_16bit
);
	import rf_synth_pkg::*;

	// ****************************************************************
	// input synchronisers and reset sources
	// ****************************************************************
	logic [9:0] in_meta;
	logic [9:0] in_sync;
	logic ext_rst_s, dig_ok_s, ana_ok_s, amp_s, alock_s, phase_s;
	logic [3:0] reg_ok_s;
	logic soft_rst;

	// two stages for every asynchronous input
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			in_meta <= 10'h001;
			in_sync <= 10'h001;
		end else begin
			in_meta <= {regulator_ready, phase_in_window, analog_lock_detect, ref_amp_stable,
				analog_supply_ok, digital_supply_ok, external_reset_n};
			in_sync <= in_meta;
		end
	end
	assign ext_rst_s = ~in_sync[0];
	assign dig_ok_s = in_sync[1];
	assign ana_ok_s = in_sync[2];
	assign amp_s = in_sync[3];
	assign alock_s = in_sync[4];
	assign phase_s = in_sync[5];
	assign reg_ok_s = in_sync[9:6];

	// pin reset and general reset command act alike
	assign soft_rst = ext_rst_s | (reg_wr && reg_addr == `REG_RESET_CMD); // RL2

	// ****************************************************************
	// write registers
	// ****************************************************************
	logic [15:0] general_control, rf_synth_control, rf_charge_pump_bleed;
	logic [15:0] rf_lock_detector_config, rf_fast_acquire_config, rf_reference_divider;
	logic [15:0] output_divider_control, interrupt_enable;
	logic [15:0] shadow_integer, rf_fraction_low, shadow_fraction_high;
	logic wr_int, wr_flow, wr_fhigh, integer_mode;

	assign wr_int = reg_wr && reg_addr == `REG_RF_INT_DIV;
	assign wr_flow = reg_wr && reg_addr == `REG_RF_FRAC_LOW;
	assign wr_fhigh = reg_wr && reg_addr == `REG_RF_FRAC_HIGH;
	assign integer_mode = rf_synth_control[`CON_MOD_MSB:`CON_MOD_LSB] == `MOD_INTEGER;

	// register storage, cleared by every reset source
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin // RL1
			general_control <= `REG_RESET_VALUE;
			rf_synth_control <= `REG_RESET_VALUE;
			rf_charge_pump_bleed <= `REG_RESET_VALUE;
			rf_lock_detector_config <= `REG_RESET_VALUE;
			rf_fast_acquire_config <= `REG_RESET_VALUE;
			rf_reference_divider <= `REG_RESET_VALUE;
			output_divider_control <= `REG_RESET_VALUE;
			interrupt_enable <= `REG_RESET_VALUE;
			shadow_integer <= `REG_RESET_VALUE;
			rf_fraction_low <= `REG_RESET_VALUE;
			shadow_fraction_high <= `REG_RESET_VALUE;
		end else if (soft_rst) begin // RL2
			general_control <= `REG_RESET_VALUE;
			rf_synth_control <= `REG_RESET_VALUE;
			rf_charge_pump_bleed <= `REG_RESET_VALUE;
			rf_lock_detector_config <= `REG_RESET_VALUE;
			rf_fast_acquire_config <= `REG_RESET_VALUE;
			rf_reference_divider <= `REG_RESET_VALUE;
			output_divider_control <= `REG_RESET_VALUE;
			interrupt_enable <= `REG_RESET_VALUE;
			shadow_integer <= `REG_RESET_VALUE;
			rf_fraction_low <= `REG_RESET_VALUE;
			shadow_fraction_high <= `REG_RESET_VALUE;
		end else if (reg_wr) begin
			unique case (reg_addr)
				`REG_GENERAL_CONTROL: general_control <= reg_wdata; // RL8
				`REG_RF_SYNTH_CONTROL: rf_synth_control <= reg_wdata;
				`REG_RF_CP_BLEED: rf_charge_pump_bleed <= reg_wdata;
				`REG_RF_LOCK_DET: rf_lock_detector_config <= reg_wdata;
				`REG_RF_FAST_ACQ: rf_fast_acquire_config <= reg_wdata;
				`REG_RF_REF_DIV: rf_reference_divider <= reg_wdata;
				`REG_OUT_DIV_CONTROL: output_divider_control <= reg_wdata;
				`REG_INTERRUPT_ENABLE: interrupt_enable <= reg_wdata;
				`REG_RF_INT_DIV: shadow_integer <= reg_wdata; // RL21
				`REG_RF_FRAC_LOW: rf_fraction_low <= reg_wdata;
				`REG_RF_FRAC_HIGH: shadow_fraction_high <= reg_wdata; // RL21
				default: ;
			endcase
		end
	end

	// ****************************************************************
	// supply monitor and reference clock hold-off
	// ****************************************************************
	clkgen_state_t clk_state;
	logic [15:0] settle_cnt;

	// power down on loss of either rail
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn)
			power_down <= 1'b1;
		else
			power_down <= ~(dig_ok_s & ana_ok_s); // RL3
	end

	// amplifier follows its own bit or either synth enable
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn)
			ref_amp_enable <= 1'b0;
		else
			ref_amp_enable <= general_control[`GC_REF_AMP_BIT] | general_control[`GC_RF_ENABLE_BIT]
				| general_control[`GC_IF_ENABLE_BIT]; // RL5
	end

	// hold the clock until the amplifier has been stable for the settle time
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			clk_state <= CLK_HOLD;
			settle_cnt <= 16'h0000;
			ref_clk_gate <= 1'b0;
		end else if (soft_rst || !ref_amp_enable || !amp_s) begin
			clk_state <= CLK_HOLD; // RL6
			settle_cnt <= 16'h0000;
			ref_clk_gate <= 1'b0;
		end else begin
			unique case (clk_state)
				CLK_HOLD: begin
					clk_state <= CLK_SETTLE;
					settle_cnt <= 16'h0000;
				end
				CLK_SETTLE: begin
					if (settle_cnt == 16'(`REF_SETTLE_CYCLES - 1)) begin
						clk_state <= CLK_RUN;
						ref_clk_gate <= 1'b1; // RL6
					end else begin
						settle_cnt <= settle_cnt + 16'h0001;
					end
				end
				CLK_RUN: ref_clk_gate <= 1'b1;
			endcase
		end
	end

	// ****************************************************************
	// divider transfer and charge pump enable
	// ****************************************************************
	logic apply;
	logic rf_en;

	assign rf_en = general_control[`GC_RF_ENABLE_BIT];
	// integer mode applies on the integer write, fractional modes on the low fraction write
	assign apply = rf_en && !soft_rst && ((integer_mode && wr_int) // RL12
		|| (!integer_mode && wr_flow)); // RL13 RL14

	// move integer and fraction to the modulator in one cycle
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			div_integer <= 16'h0000;
			div_fraction <= 24'h000000;
			div_update <= 1'b0;
		end else if (soft_rst) begin
			div_integer <= 16'h0000;
			div_fraction <= 24'h000000;
			div_update <= 1'b0;
		end else begin
			div_update <= apply;
			if (apply && integer_mode) begin
				div_integer <= reg_wdata; // RL12
				div_fraction <= 24'h000000;
			end else if (apply && rf_synth_control[`CON_RES16_BIT]) begin
				div_integer <= shadow_integer; // RL13 RL21
				div_fraction <= {reg_wdata, 8'h00};
			end else if (apply) begin
				div_integer <= shadow_integer; // RL14 RL21
				div_fraction <= {shadow_fraction_high[7:0], reg_wdata}; // RL18 RL19
			end
		end
	end

	// modulator order and resolution follow the control register
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			modulator_select <= `MOD_INTEGER;
			fraction_16bit <= 1'b0;
		end else begin
			modulator_select <= rf_synth_control[`CON_MOD_MSB:`CON_MOD_LSB]; // RL20
			fraction_16bit <= rf_synth_control[`CON_RES16_BIT]; // RL20
		end
	end

	// charge pump high impedance until the first divider load after enable
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn)
			cp_enable <= 1'b0;
		else if (soft_rst || !rf_en)
			cp_enable <= 1'b0; // RL9
		else if (apply)
			cp_enable <= 1'b1; // RL11
	end

	// ****************************************************************
	// fastlock sequence
	// ****************************************************************
	logic [4:0] tick_cnt;
	logic us_tick;
	logic [11:0] fast_cnt;

	// one microsecond enable pulse
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			tick_cnt <= 5'h00;
			us_tick <= 1'b0;
		end else if (tick_cnt == 5'(`US_TICK_CYCLES - 1)) begin
			tick_cnt <= 5'h00;
			us_tick <= 1'b1;
		end else begin
			tick_cnt <= tick_cnt + 5'h01;
			us_tick <= 1'b0;
		end
	end

	// start on each applied update, run for the programmed microseconds
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			fast_cnt <= 12'h000;
			fast_acquire_output <= 1'b0;
			cp_gain_boost <= 1'b0;
		end else if (soft_rst || !rf_en) begin
			fast_cnt <= 12'h000;
			fast_acquire_output <= 1'b0;
			cp_gain_boost <= 1'b0;
		end else if (apply && rf_lock_detector_config[`LD_FAST_EN_BIT]) begin
			fast_cnt <= rf_fast_acquire_config[`FA_TIME_MSB:0]; // RL15
			fast_acquire_output <= 1'b1; // RL16
			cp_gain_boost <= 1'b1;
		end else if (fast_acquire_output && us_tick) begin
			if (fast_cnt <= 12'h001) begin
				fast_acquire_output <= 1'b0; // RL16
				cp_gain_boost <= 1'b0;
				fast_cnt <= 12'h000;
			end else begin
				fast_cnt <= fast_cnt - 12'h001;
			end
		end
	end

	// ****************************************************************
	// lock detector
	// ****************************************************************
	logic [7:0] lock_cnt;

	// analogue: follow the comparator; digital: count in-window cycles
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			lock_cnt <= 8'h00;
			rf_lock <= 1'b0;
		end else if (soft_rst || !cp_enable || apply) begin
			lock_cnt <= 8'h00;
			rf_lock <= 1'b0;
		end else if (!rf_lock_detector_config[`LD_DIGITAL_BIT]) begin
			rf_lock <= alock_s; // RL17
		end else if (!phase_s) begin
			lock_cnt <= 8'h00;
			rf_lock <= 1'b0;
		end else if (lock_cnt >= rf_lock_detector_config[`LD_COUNT_MSB:`LD_COUNT_LSB]) begin
			rf_lock <= 1'b1; // RL17
		end else begin
			lock_cnt <= lock_cnt + 8'h01;
		end
	end

	// ****************************************************************
	// read port
	// ****************************************************************
	logic [15:0] device_status;
	assign device_status = {8'h00, ref_clk_gate, 5'h00, fast_acquire_output, rf_lock}; // RL7

	// one cycle after the strobe the word is returned
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			reg_rdata <= 16'h0000;
			reg_rvalid <= 1'b0;
		end else begin
			reg_rvalid <= reg_rd;
			if (reg_rd) begin
				unique case (reg_addr)
					`REG_GENERAL_CONTROL_RB: reg_rdata <= general_control;
					`REG_DEVICE_STATUS: reg_rdata <= device_status; // RL7
					`REG_INTERRUPT_ENABLE: reg_rdata <= interrupt_enable;
					`REG_POWER_STATUS: reg_rdata <= {12'h000, reg_ok_s}; // RL4
					`REG_RF_REF_DIV_RB: reg_rdata <= rf_reference_divider;
					`REG_RF_INT_DIV_RB: reg_rdata <= shadow_integer;
					`REG_RF_FRAC_LOW_RB: reg_rdata <= rf_fraction_low;
					`REG_RF_FRAC_HIGH_RB: reg_rdata <= shadow_fraction_high;
					`REG_OUT_DIV_RB: reg_rdata <= output_divider_control;
					default: reg_rdata <= 16'h0000;
				endcase
			end
		end
	end

	// ****************************************************************
	// assertions
	// ****************************************************************
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);

	AST_POWER_DOWN: assert property (!(dig_ok_s && ana_ok_s) |=> power_down) // RL3
		else $error("power down missed supply loss");
	AST_SOFT_RESET: assert property (soft_rst |=> general_control == 16'h0000 && !cp_enable
		&& !ref_clk_gate && !fast_acquire_output) // RL2
		else $error("soft reset left state behind");
	AST_POR_STATE: assert property ($rose(rstn) |-> general_control == 16'h0000) // RL1
		else $error("registers not cleared by power on reset");
	AST_AMP_ON: assert property (general_control[2] || general_control[3] |=> ref_amp_enable) // RL5
		else $error("reference amplifier not enabled");
	AST_GATE_STABLE: assert property (!amp_s |=> !ref_clk_gate) // RL6
		else $error("clock released while unstable");
	AST_GATE_RISE: assert property ($rose(ref_clk_gate) |-> $past(amp_s, 1) && $past(amp_s, 2)) // RL6
		else $error("clock released without settle");
	AST_STATUS_B7: assert property (reg_rd && reg_addr == 8'hc4 |=>
		reg_rvalid && reg_rdata[7] == $past(ref_clk_gate)) // RL7
		else $error("status bit 7 wrong");
	AST_PWR_STATUS: assert property (reg_rd && reg_addr == 8'hc6 |=>
		reg_rdata[3:0] == $past(reg_ok_s)) // RL4
		else $error("power status wrong");
	AST_CP_HIZ: assert property ($rose(cp_enable) |-> $past(apply)) // RL9
		else $error("charge pump enabled before divider load");
	AST_RF_OFF: assert property (!rf_en |=> !cp_enable) // RL8
		else $error("charge pump on while rf disabled");
	AST_INT_NOW: assert property (rf_en && integer_mode && wr_int && !soft_rst |=>
		div_update && div_integer == $past(reg_wdata) && cp_enable) // RL12
		else $error("integer write not applied");
	AST_FRAC_WAIT: assert property (!integer_mode && (wr_int || wr_fhigh) && !wr_flow |=>
		!div_update) // RL14
		else $error("fractional ratio applied early");
	AST_FRAC24: assert property (rf_en && !integer_mode && !rf_synth_control[9] && wr_flow
		&& !soft_rst |=> div_fraction == {$past(shadow_fraction_high[7:0]), $past(reg_wdata)}) // RL21
		else $error("24-bit fraction not transferred whole");
	AST_FAST_START: assert property (apply && rf_lock_detector_config[12] |=>
		fast_acquire_output && cp_gain_boost) // RL15
		else $error("fastlock not started");
	AST_FAST_PAIR: assert property (fast_acquire_output == cp_gain_boost) // RL16
		else $error("fastlock pin and gain boost disagree");

	COV_INT_LOAD: cover property (rf_en && integer_mode && wr_int ##1 cp_enable);
	COV_FAST_RUN: cover property ($rose(fast_acquire_output) ##[1:200] $fell(fast_acquire_output));
	COV_CLK_REL: cover property ($rose(ref_clk_gate));
	COV_LOCK: cover property ($rose(rf_lock));
endmodule
`default_nettype wire

// File: test/analog_front_model.sv
// behavioural model of the reference amplifier and the analogue lock comparator
`timescale 1ns/1ns
`default_nettype none
module analog_front_model (
	// clock and reset
	input wire logic clk,
	input wire logic rstn,
	// reference amplifier
	input wire logic amp_enable,
	output logic amp_stable,
	// loop comparator
	input wire logic pump_on,
	output logic comparator_lock
);
	logic [3:0] amp_count;
	logic [3:0] loop_count;

	// amplifier output is unstable for a while after enable
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			amp_count <= 4'h0;
		end else if (!amp_enable) begin
			amp_count <= 4'h0;
		end else if (amp_count != 4'hf) begin
			amp_count <= amp_count + 4'h1;
		end
	end

	// loop settles some cycles after the pump starts driving
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			loop_count <= 4'h0;
		end else if (!pump_on) begin
			loop_count <= 4'h0;
		end else if (loop_count != 4'hf) begin
			loop_count <= loop_count + 4'h1;
		end
	end

	// status levels seen by the device
	assign amp_stable = (amp_count > 4'h7);
	assign comparator_lock = (loop_count > 4'h7);
endmodule
`default_nettype wire

// File: test/rf_fracn_synth_control_test.sv
// self-checking bench of the rf synth control through its register port
`timescale 1ns/1ns
`default_nettype none
module rf_fracn_synth_control_test;
	logic clk, rstn, external_reset_n, digital_supply_ok, analog_supply_ok;
	logic [3:0] regulator_ready;
	logic power_down, ref_amp_stable, ref_amp_enable, ref_clk_gate;
	logic reg_wr, reg_rd, reg_rvalid, analog_lock_detect, phase_in_window;
	logic [7:0] reg_addr;
	logic [15:0] reg_wdata, reg_rdata, div_integer;
	logic cp_enable, cp_gain_boost, fast_acquire_output, rf_lock, div_update;
	logic [23:0] div_fraction;
	logic [3:0] modulator_select;
	logic fraction_16bit;
	int bad_count = 0;
	int tests_run = 0;
	int upd_count = 0;

	rf_fracn_synth_control u_rf_fracn_synth_control (.clk(clk), .rstn(rstn),
		.external_reset_n(external_reset_n), .digital_supply_ok(digital_supply_ok),
		.analog_supply_ok(analog_supply_ok), .regulator_ready(regulator_ready),
		.power_down(power_down), .ref_amp_stable(ref_amp_stable),
		.ref_amp_enable(ref_amp_enable), .ref_clk_gate(ref_clk_gate), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
		.reg_rvalid(reg_rvalid), .analog_lock_detect(analog_lock_detect),
		.phase_in_window(phase_in_window), .cp_enable(cp_enable),
		.cp_gain_boost(cp_gain_boost), .fast_acquire_output(fast_acquire_output),
		.rf_lock(rf_lock), .div_integer(div_integer), .div_fraction(div_fraction),
		.div_update(div_update), .modulator_select(modulator_select),
		.fraction_16bit(fraction_16bit));

	analog_front_model u_analog_front_model (.clk(clk), .rstn(rstn),
		.amp_enable(ref_amp_enable), .amp_stable(ref_amp_stable),
		.pump_on(cp_enable), .comparator_lock(analog_lock_detect));

	// 25 mhz clock
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end

	// counts modulator updates
	always @(posedge clk) begin
		if (div_update === 1'b1) upd_count++;
	end

	task automatic close_out;
		$display("checks %0d mismatches %0d", tests_run, bad_count);
		if (bad_count == 0 && tests_run > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	task automatic chk(input string what, input logic [23:0] seen, input logic [23:0] exp);
		tests_run++;
		if (seen !== exp) begin
			bad_count++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		@(posedge clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk);
		reg_wr <= 1'b0;
		#1;
	endtask

	// read, then compare valid flag and data together
	task automatic rd_chk(input logic [7:0] a, input logic [15:0] e);
		@(posedge clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1;
		chk("read data", {7'h00, reg_rvalid, reg_rdata}, {7'h00, 1'b1, e});
	endtask

	function automatic logic pick(input int k);
		case (k)
			0: return ref_clk_gate;
			1: return rf_lock;
			default: return fast_acquire_output;
		endcase
	endfunction

	// bounded wait for a level on a selected output
	task automatic wait_sig(input int k, input logic v, input int lim);
		int i;
		i = 0;
		while (pick(k) !== v && i < lim) begin
			@(posedge clk);
			#1;
			i++;
		end
	endtask

	task automatic idle(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	// watchdog
	initial begin
		repeat (20000) @(posedge clk);
		bad_count++;
		close_out();
	end

	// ****************************************************************
	// main sequence
	// ****************************************************************
	initial begin
		rstn = 1'b0;
		external_reset_n = 1'b1;
		digital_supply_ok = 1'b1;
		analog_supply_ok = 1'b1;
		regulator_ready = 4'ha;
		phase_in_window = 1'b0;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_addr = 8'h00;
		reg_wdata = 16'h0000;
		idle(10);
		chk("power down in reset", power_down, 1'b1);
		rstn <= 1'b1;
		idle(6);
		chk("power down", power_down, 1'b0);
		rd_chk(8'hc6, 16'h000a);
		rd_chk(8'h31, 16'h0000);
		rd_chk(8'h77, 16'h0000);
		analog_supply_ok <= 1'b0;
		idle(5);
		chk("power down on loss", power_down, 1'b1);
		analog_supply_ok <= 1'b1;
		idle(5);
		// enable comes first
		wr(8'h31, 16'h0004);
		idle(2);
		chk("amp enable", ref_amp_enable, 1'b1);
		chk("pump idle", cp_enable, 1'b0);
		idle(100);
		chk("clock held", ref_clk_gate, 1'b0);
		wait_sig(0, 1'b1, 300);
		chk("clock released", ref_clk_gate, 1'b1);
		rd_chk(8'hc4, 16'h0080);
		// setup before the main divider
		wr(8'h34, 16'h0000);
		wr(8'h36, 16'h0000);
		wr(8'h37, 16'h0002);
		wr(8'h38, 16'h0001);
		chk("pump idle", cp_enable, 1'b0);
		wr(8'h39, 16'h00b8);
		chk("update pulse", {div_update, div_integer}, {1'b1, 16'h00b8});
		idle(1);
		chk("pump on", cp_enable, 1'b1);
		wait_sig(1, 1'b1, 40);
		chk("analogue lock", rf_lock, 1'b1);
		// 24-bit fractional, shadowed pair
		wr(8'h34, 16'h6800);
		idle(1); // modulator copy lags the control write by one cycle
		chk("modulator", {fraction_16bit, modulator_select}, 5'h0d);
		upd_count = 0;
		wr(8'h39, 16'h00b9);
		wr(8'h3b, 16'h0098);
		idle(2);
		chk("no early apply", {upd_count[7:0], div_integer}, 24'h0000b8);
		wr(8'h3a, 16'haaab);
		chk("update pulse", div_update, 1'b1);
		chk("integer", div_integer, 16'h00b9);
		chk("fraction", div_fraction, 24'h98aaab);
		rd_chk(8'hc9, 16'h00b9);
		// 16-bit fractional
		wr(8'h34, 16'h6a00);
		idle(1);
		chk("res16", fraction_16bit, 1'b1);
		upd_count = 0;
		wr(8'h39, 16'h00c0);
		idle(2);
		chk("no early apply", upd_count[23:0], 24'h000000);
		wr(8'h3a, 16'h1234);
		chk("fraction16", div_fraction, 24'h123400);
		chk("integer16", div_integer, 16'h00c0);
		// fastlock with digital lock count 3
		wr(8'h36, 16'h1031);
		phase_in_window <= 1'b1;
		wr(8'h3a, 16'h0001);
		chk("fastlock on", {fast_acquire_output, cp_gain_boost}, 2'b11);
		idle(20);
		chk("fastlock held", {fast_acquire_output, cp_gain_boost}, 2'b11);
		wait_sig(2, 1'b0, 40);
		chk("fastlock end", {fast_acquire_output, cp_gain_boost}, 2'b00);
		wait_sig(1, 1'b1, 20);
		chk("digital lock", rf_lock, 1'b1);
		phase_in_window <= 1'b0;
		wait_sig(1, 1'b0, 8);
		chk("lock lost", rf_lock, 1'b0);
		wr(8'h36, 16'h0000);
		wr(8'h3a, 16'h0002);
		chk("no fastlock", fast_acquire_output, 1'b0);
		// reset pin
		external_reset_n <= 1'b0;
		idle(5);
		chk("pin reset", {ref_clk_gate, ref_amp_enable, cp_enable, div_integer}, 0);
		external_reset_n <= 1'b1;
		idle(4);
		rd_chk(8'hc9, 16'h0000);
		// general reset command
		wr(8'h31, 16'h0004);
		wr(8'h39, 16'h0055);
		chk("integer", div_integer, 16'h0055);
		wr(8'h01, 16'h0000);
		idle(2);
		chk("command reset", {ref_amp_enable, cp_enable, div_integer}, 0);
		rd_chk(8'hc9, 16'h0000);
		close_out();
	end
endmodule
`default_nettype wire
